//--- src/scan_edge_detect_on_delay_timer.v
// Purpose: Falling-edge contact, rising and falling coils, on-delay timer
// Assumes: Inputs synchronous; one scan per scan_strobe_in pulse
// Notes: Timer results update on the strobe, edge results one clock later; each holds for one whole scan
`timescale 1ns/100ps
`default_nettype none
`include "scan_prim_map.vh"
module scan_edge_detect_on_delay_timer #(
  parameter integer TW = `TMR_WIDTH,
  parameter integer FINE_CYC = `FINE_BASE_CYC,
  parameter integer COARSE_CYC = `COARSE_BASE_CYC
) (
  // Clock and reset
  input wire clock_in,
  input wire rst_b_in,
  // Scan strobe
  input wire scan_strobe_in,
  // Falling-edge contact
  input wire fc_rung_in,
  input wire fc_device_in,
  output reg fc_out,
  // Edge coils
  input wire rc_rung_in,
  output reg rc_device_out,
  input wire nc_rung_in,
  output reg nc_device_out,
  // On-delay timing element
  input wire on_delay_timing_element_in,
  input wire [TW-1:0] set_time_in,
  input wire coarse_base_in,
  output reg on_delay_timing_element_out,
  output reg [TW-1:0] timer_current_value_word_out
);
  // ****************
  // Edge cells
  // ****************
  wire fc_fall;
  wire rc_rise;
  wire nc_fall;
  wire [2:0] sense_w;
  wire [2:0] rise_w;
  wire [2:0] fall_w;
  assign sense_w = {nc_rung_in, rc_rung_in, fc_device_in};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_edge
      scan_edge_cell u_cell (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .scan_strobe_in(scan_strobe_in),
        .sense_in(sense_w[gi]),
        .rise_out(rise_w[gi]),
        .fall_out(fall_w[gi])
      );
    end
  endgenerate
  assign fc_fall = fall_w[0];
  assign rc_rise = rise_w[1];
  assign nc_fall = fall_w[2];
  // Rung levels aligned to the cell outputs
  reg fc_rung_d_ff;
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fc_rung_d_ff <= 1'b0;
    end else if (scan_strobe_in) begin
      fc_rung_d_ff <= fc_rung_in;
    end
  end
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fc_out <= 1'b0;
      rc_device_out <= 1'b0;
      nc_device_out <= 1'b0;
    end else begin
      fc_out <= fc_rung_d_ff & fc_fall; // [RULE_01] [RULE_02]
      rc_device_out <= rc_rise; // [RULE_03] [RULE_04]
      nc_device_out <= nc_fall; // [RULE_05]
    end
  end
  // ****************
  // Helpers
  // ****************
  // Time-up test shared by the state machine and the output
  function time_up;
    input [TW-1:0] cur;
    input [TW-1:0] lim;
    begin
      time_up = (cur >= lim);
    end
  endfunction
  // Add with a ceiling at the set time; a value already there holds
  function [TW-1:0] sat_add;
    input [TW-1:0] cur;
    input [TW-1:0] inc;
    input [TW-1:0] lim;
    reg [TW:0] sum;
    begin
      sum = {1'b0, cur} + {1'b0, inc};
      if (cur >= lim) begin
        sat_add = cur;
      end else if (sum > {1'b0, lim}) begin
        sat_add = lim;
      end else begin
        sat_add = sum[TW-1:0];
      end
    end
  endfunction
  localparam [TW-1:0] ZERO_TW = {TW{1'b0}};
  localparam [TW-1:0] ONE_TW = {{(TW-1){1'b0}}, 1'b1};
  // ****************
  // Time base
  // ****************
  localparam integer FINE_LIM_I = FINE_CYC - 1;
  localparam integer COARSE_LIM_I = COARSE_CYC - 1;
  localparam [23:0] FINE_LIM = FINE_LIM_I[23:0];
  localparam [23:0] COARSE_LIM = COARSE_LIM_I[23:0];
  reg [23:0] base_cnt_ff;
  reg [23:0] nxt_base_cnt;
  reg [23:0] base_lim;
  reg tick_ff;
  reg nxt_tick;
  // Clocks per count chosen by timer group
  always @* begin
    if (coarse_base_in) begin
      base_lim = COARSE_LIM; // [RULE_11]
    end else begin
      base_lim = FINE_LIM; // [RULE_11]
    end
  end
  // Idles at zero while the input is off
  always @* begin
    nxt_base_cnt = base_cnt_ff + 24'h000001;
    nxt_tick = 1'b0;
    if (!on_delay_timing_element_in) begin
      nxt_base_cnt = 24'h000000; // [RULE_10]
    end else if (base_cnt_ff >= base_lim) begin
      nxt_base_cnt = 24'h000000;
      nxt_tick = 1'b1; // [RULE_07]
    end
  end
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      base_cnt_ff <= 24'h000000;
      tick_ff <= 1'b0;
    end else begin
      base_cnt_ff <= nxt_base_cnt;
      tick_ff <= nxt_tick;
    end
  end
  // ****************
  // Tick accumulator
  // ****************
  // Ticks between strobes are summed and handed over at the strobe
  reg [TW-1:0] ticks_ff;
  reg [TW-1:0] nxt_ticks;
  always @* begin
    nxt_ticks = ticks_ff;
    if (!on_delay_timing_element_in) begin
      nxt_ticks = ZERO_TW; // [RULE_10]
    end else if (scan_strobe_in) begin
      nxt_ticks = tick_ff ? ONE_TW : ZERO_TW;
    end else if (tick_ff) begin
      nxt_ticks = ticks_ff + ONE_TW;
    end
  end
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ticks_ff <= ZERO_TW;
    end else begin
      ticks_ff <= nxt_ticks;
    end
  end
  // ****************
  // On-delay timer
  // ****************
  // Idle, counting, timed out
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_TIMING = 2'b01;
  localparam [1:0] ST_UP = 2'b10;
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [TW-1:0] nxt_cur;
  reg nxt_done;
  always @* begin
    nxt_state = state_ff;
    nxt_cur = timer_current_value_word_out;
    nxt_done = on_delay_timing_element_out;
    if (!on_delay_timing_element_in) begin
      nxt_state = ST_IDLE;
      nxt_cur = ZERO_TW; // [RULE_10]
      nxt_done = 1'b0; // [RULE_10]
    end else begin
      case (state_ff)
        ST_IDLE: begin
          nxt_cur = sat_add(ZERO_TW, ticks_ff, set_time_in); // [RULE_07]
        end
        ST_TIMING: begin
          nxt_cur = sat_add(timer_current_value_word_out, ticks_ff, set_time_in); // [RULE_07]
        end
        ST_UP: begin
          nxt_cur = timer_current_value_word_out; // [RULE_09]
        end
        default: begin
          nxt_cur = ZERO_TW;
        end
      endcase
      nxt_done = time_up(nxt_cur, set_time_in); // [RULE_06] [RULE_09]
      if (nxt_done) begin
        nxt_state = ST_UP;
      end else begin
        nxt_state = ST_TIMING;
      end
    end
  end
  // Results land on the strobe and stand for a scan
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_ff <= ST_IDLE;
      timer_current_value_word_out <= ZERO_TW;
      on_delay_timing_element_out <= 1'b0;
    end else if (scan_strobe_in) begin
      state_ff <= nxt_state;
      timer_current_value_word_out <= nxt_cur; // [RULE_07]
      on_delay_timing_element_out <= nxt_done; // [RULE_06]
    end
  end
endmodule // scan_edge_detect_on_delay_timer
`default_nettype wire

//--- src/scan_prim_map.vh
// Purpose: Constants for the scan-cycle edge and on-delay timing primitives
// Assumes: One 100 MHz clock; scan advance is a one-cycle strobe
// Notes: Time base figures in microseconds per count
// Function
// [RULE_01] The falling-edge contact gives ON for exactly one scan when its input is ON and the watched bit fell.
// [RULE_02] The falling-edge contact gives OFF in every other case.
// [RULE_03] The rising-edge coil writes ON for one scan when its input is ON now and was OFF last scan.
// [RULE_04] The rising-edge coil writes OFF when its input is OFF or was already ON last scan.
// [RULE_05] The falling-edge coil writes ON for one scan when its input is OFF now and was ON last scan, else OFF.
// [RULE_06] The timer output is OFF while the current value is below the set time and ON once it reaches it.
// [RULE_07] While the input is ON before time-up the current value grows by elapsed time and is readable.
// [RULE_08] The program keeps a constant set time within 0 to 32767 and never indexes it.
// [RULE_09] After time-up the current value holds and the output stays ON while the input stays ON.
// [RULE_10] When the input drops the current value clears to zero and the output goes OFF, with no timing while OFF.
// [RULE_11] Lower timers count 0.01 s per count and higher ones 0.1 s per count, with a model-dependent boundary.
// [RULE_12] Each edge detector keeps its own previous-scan copy, updated on the scan strobe.
`ifndef SCAN_PRIM_MAP_VH
`define SCAN_PRIM_MAP_VH
`define CLK_PERIOD_NS 10
`define FINE_BASE_US 10000
`define COARSE_BASE_US 100000
`define FINE_BASE_CYC ((`FINE_BASE_US * 1000) / `CLK_PERIOD_NS)
`define COARSE_BASE_CYC ((`COARSE_BASE_US * 1000) / `CLK_PERIOD_NS)
`define TMR_WIDTH 16
`define SET_TIME_MAX 16'h7FFF
`define TMR_RESET 16'h0000
`endif

//--- src/scan_edge_cell.v
// Purpose: One edge detector with a private previous-scan copy
// Assumes: Scan strobe is a one-cycle pulse
// Notes: Results registered on the scan strobe
`timescale 1ns/100ps
`default_nettype none
module scan_edge_cell (
  // Clock and reset
  input wire clock_in,
  input wire rst_b_in,
  // Scan
  input wire scan_strobe_in,
  input wire sense_in,
  // Edges
  output reg rise_out,
  output reg fall_out
);
  reg prev_ff;
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prev_ff <= 1'b0;
      rise_out <= 1'b0;
      fall_out <= 1'b0;
    end else if (scan_strobe_in) begin
      prev_ff <= sense_in; // [RULE_12]
      rise_out <= sense_in & ~prev_ff; // [RULE_12]
      fall_out <= ~sense_in & prev_ff; // [RULE_12]
    end
  end
endmodule // scan_edge_cell
`default_nettype wire

//--- test/scan_tmr_monitor.sv
// Purpose: Port checker for the scan primitives
// Assumes: Edge results 2 cycles, timer 1 cycle after a strobe
// Notes: Set time held steady by the driver
`timescale 1ns/100ps
`default_nettype none
module scan_tmr_monitor #(
  parameter integer TW = 16
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Edge primitives
  input wire logic scan_strobe_in,
  input wire logic fc_rung_in,
  input wire logic fc_device_in,
  input wire logic fc_out,
  input wire logic rc_rung_in,
  input wire logic rc_device_out,
  input wire logic nc_rung_in,
  input wire logic nc_device_out,
  // Timer
  input wire logic coarse_base_in,
  input wire logic on_delay_timing_element_in,
  input wire logic on_delay_timing_element_out,
  input wire logic [TW-1:0] set_time_in,
  input wire logic [TW-1:0] timer_current_value_word_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  property p_fc_on;
    $rose(fc_out) |-> $past(fc_rung_in, 2) && !$past(fc_device_in, 2);
  endproperty
  a_fc_on: assert property (p_fc_on) else $error("contact on without fall");
  property p_fc_off;
    $past(scan_strobe_in, 2) && (!$past(fc_rung_in, 2) || $past(fc_device_in, 2)) |-> !fc_out;
  endproperty
  a_fc_off: assert property (p_fc_off) else $error("contact not off");
  property p_rc_on;
    $rose(rc_device_out) |-> $past(scan_strobe_in, 2) && $past(rc_rung_in, 2);
  endproperty
  a_rc_on: assert property (p_rc_on) else $error("rise coil on without cause");
  property p_rc_off;
    $past(scan_strobe_in, 2) && !$past(rc_rung_in, 2) |-> !rc_device_out;
  endproperty
  a_rc_off: assert property (p_rc_off) else $error("rise coil not off");
  property p_nc_off;
    $past(scan_strobe_in, 2) && $past(nc_rung_in, 2) |-> !nc_device_out;
  endproperty
  a_nc_off: assert property (p_nc_off) else $error("fall coil not off");
  property p_nc_on;
    $rose(nc_device_out) |-> $past(scan_strobe_in, 2) && !$past(nc_rung_in, 2);
  endproperty
  a_nc_on: assert property (p_nc_on) else $error("fall coil on without cause");
  property p_up;
    on_delay_timing_element_out |-> timer_current_value_word_out >= set_time_in;
  endproperty
  a_up: assert property (p_up) else $error("timer on early");
  property p_grow;
    on_delay_timing_element_in && $past(on_delay_timing_element_in)
      |-> timer_current_value_word_out >= $past(timer_current_value_word_out);
  endproperty
  a_grow: assert property (p_grow) else $error("value fell while timing");
  property p_hold;
    on_delay_timing_element_out && on_delay_timing_element_in |=> $stable(timer_current_value_word_out);
  endproperty
  a_hold: assert property (p_hold) else $error("value moved after time-up");
  property p_clr;
    scan_strobe_in && !on_delay_timing_element_in
      |=> timer_current_value_word_out == '0 && !on_delay_timing_element_out;
  endproperty
  a_clr: assert property (p_clr) else $error("timer not cleared");
endmodule // scan_tmr_monitor
bind scan_edge_detect_on_delay_timer scan_tmr_monitor #(.TW(TW)) scan_tmr_monitor_inst (
  .clock_in(clock_in),
  .rst_b_in(rst_b_in),
  .scan_strobe_in(scan_strobe_in),
  .fc_rung_in(fc_rung_in),
  .fc_device_in(fc_device_in),
  .fc_out(fc_out),
  .rc_rung_in(rc_rung_in),
  .rc_device_out(rc_device_out),
  .nc_rung_in(nc_rung_in),
  .nc_device_out(nc_device_out),
  .coarse_base_in(coarse_base_in),
  .on_delay_timing_element_in(on_delay_timing_element_in),
  .on_delay_timing_element_out(on_delay_timing_element_out),
  .set_time_in(set_time_in),
  .timer_current_value_word_out(timer_current_value_word_out)
);
`default_nettype wire

//--- test/scan_exec_model.sv
// Purpose: Scan executive giving strobes
// Assumes: Strobe spacing alternates 3 and 7 cycles
// Notes: Quiet during reset
`timescale 1ns/100ps
`default_nettype none
module scan_exec_model (input wire logic clock_in, input wire logic rst_b_in, output logic strobe_out);
  logic [2:0] cnt_ff;
  logic slow_ff;
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      {cnt_ff, slow_ff, strobe_out} <= 5'h00;
    end else begin
      strobe_out <= cnt_ff == 3'h0;
      cnt_ff <= (cnt_ff == 3'h0) ? (slow_ff ? 3'h6 : 3'h2) : cnt_ff - 3'h1;
      slow_ff <= slow_ff ^ (cnt_ff == 3'h0);
    end
  end
endmodule // scan_exec_model
`default_nettype wire

//--- test/scan_edge_detect_on_delay_timer_tb_top.sv
// Purpose: Bench for edge primitives and timer
// Assumes: Edge inputs change 1 ns after a strobe edge; timer inputs 1 ns after any clock edge
// Notes: Edge results queued and compared by a watcher
`timescale 1ns/100ps
`default_nettype none
module scan_edge_detect_on_delay_timer_tb_top;
  logic clock_in = 0, rst_b_in = 0, stb, fr = 0, fd = 0, rr = 0, nr = 0, ti = 0, cb = 0, fo, ro, no, to;
  logic [15:0] st = 16'h0003, cv;
  logic [2:0] q[$], e, prv = 3'h0;
  int n_fail = 0, comparisons = 0, seed = 19, cyc = 0;
  always #5 clock_in = ~clock_in;
  scan_exec_model scan_exec_model_inst (.clock_in, .rst_b_in, .strobe_out(stb));
  scan_edge_detect_on_delay_timer #(.FINE_CYC(4), .COARSE_CYC(40)) scan_edge_detect_on_delay_timer_inst (
    .clock_in, .rst_b_in, .scan_strobe_in(stb), .fc_rung_in(fr), .fc_device_in(fd), .fc_out(fo),
    .rc_rung_in(rr), .rc_device_out(ro), .nc_rung_in(nr), .nc_device_out(no), .on_delay_timing_element_in(ti),
    .set_time_in(st), .coarse_base_in(cb), .on_delay_timing_element_out(to), .timer_current_value_word_out(cv));
  task automatic chk(input logic [15:0] s, x, input string n);
    comparisons++;
    if (s !== x) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clock_in) if (stb && q.size() > 0) begin
    repeat (2) @(posedge clock_in);
    #1 e = q.pop_front();
    chk({fo, ro, no}, e, "edges");
  end
  always @(posedge clock_in) if (++cyc > 4000) begin
    n_fail++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge clock_in);
    #1 rst_b_in = 1;
    for (int i = 0; i < 80; i++) begin
      {fr, fd, rr, nr} = $random(seed);
      q.push_back({fr & prv[2] & ~fd, rr & ~prv[1], ~nr & prv[0]});
      prv = {fd, rr, nr};
      do @(posedge clock_in); while (!stb);
      #1 chk(cv, 16'h0000, "idle value");
    end
    $display("edge test done");
    for (int b = 0; b < 2; b++) begin
      cb = b;
      st = $random(seed) & 16'h000F;
      ti = 1;
      repeat (700) @(posedge clock_in);
      #1 chk(to, 1, "timer out");
      chk(cv, st, "held value");
      ti = 0;
      repeat (10) @(posedge clock_in);
      #1 chk(cv, 16'h0000, "cleared value");
      chk(to, 16'h0000, "cleared out");
      $display("timer test done");
    end
    summarize();
  end
endmodule // scan_edge_detect_on_delay_timer_tb_top
`default_nettype wire
